// File: design/pnvt_top.sv
// SMBus command block: nonvolatile store and restore, capability, format and input thresholds
`timescale 1ns/1ns
`default_nettype none
`include "pnvt_consts.svh"
// How it works
// RULE_01 - Command 15h stores settings to nonvolatile memory
// RULE_02 - Store allowed while switching; faults ignored meanwhile
// RULE_03 - Failed store: NACK, set cml and oth
// RULE_04 - Command 16h reloads settings from nonvolatile memory
// RULE_05 - Restore while switching stops drivers, then restarts
// RULE_06 - Host should stop conversion before restoring
// RULE_07 - Command 19h reads fixed capability byte b0h
// RULE_08 - Command 20h reads linear mode, exponent minus nine
// RULE_09 - Format byte fields cannot be written
// RULE_10 - 35h holds turn-on, 36h turn-off input level
// RULE_11 - In-range thresholds snap to nearest supported value
// RULE_12 - Out-of-range write kept out; set cml, ivd
// RULE_13 - Turn-on set spans 4.25 to 16 volts
// RULE_14 - Turn-off set spans 4 to 15.75 volts
// RULE_15 - Misordered thresholds rejected; alert, cml, ivd set
// RULE_16 - Turn-on word: exponent minus two, seven-bit mantissa
// RULE_17 - Turn-off word uses the same fixed layout
// RULE_18 - Turn-on mantissa resets to 17
// RULE_19 - Turn-off mantissa resets to 16
// RULE_20 - Both thresholds belong to the stored settings
// RULE_21 - Fixed exponent and mantissa bits ignore writes
module pnvt_top (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     scl_clk,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  output logic                          smbalert_out,
  output logic                          smbalert_oe,
  input  wire logic                     switching,
  input  wire logic                     clear_faults,
  output logic                          cml_flag,
  output logic                          oth_flag,
  output logic                          ivd_flag,
  output logic                          fault_ignore,
  output logic                          drivers_off,
  output logic                          conv_restart,
  output pnvt_pkg::pnvt_mant_t          turn_on_mant,
  output pnvt_pkg::pnvt_mant_t          turn_off_mant,
  output logic                          nvm_wr,
  output logic                          nvm_rd,
  output pnvt_pkg::pnvt_nvm_word_t      nvm_wdata,
  input  wire pnvt_pkg::pnvt_nvm_word_t nvm_rdata,
  input  wire logic                     nvm_done,
  input  wire logic                     nvm_fail,
  input  wire logic                     nvm_blank
);
  import pnvt_pkg::*;

  // Link side, clocked by the bus clock and by data edges
  logic       start_tgl;
  logic       stop_tgl;
  logic       start_seen;
  logic       new_frame;
  pnvt_byte_t shift_in;
  logic       ack_in;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic       addressed;
  logic       rd_mode;
  logic       rd_act;
  logic       rd_idx;
  pnvt_byte_t rd_shift;
  pnvt_byte_t next_rd_byte;
  pnvt_byte_t f_cmd;
  pnvt_byte_t f_lo;
  logic [1:0] f_nwr;
  logic       nack_meta;
  logic       nack_sync;
  logic       shd_meta;
  logic       shd_sync;
  logic       shd_seen;
  pnvt_mant_t rd_on;
  pnvt_mant_t rd_off;

  // Core side, clocked by clk
  logic       stp_meta;
  logic       stp_sync;
  logic       stp_seen;
  logic       frame_end;
  logic       wr_frame;
  logic       thr_write;
  logic       sel_on;
  logic       in_range;
  pnvt_mant_t snapped;
  logic       order_bad;
  logic       thr_accept;
  logic       shd_tgl;
  logic       nack_req;
  logic       range_err;
  logic       order_err;

  pnvt_nvm_if nv ();

  function automatic pnvt_byte_t read_byte(input pnvt_byte_t cmd, input logic hi,
                                           input pnvt_mant_t on_m, input pnvt_mant_t off_m);
    pnvt_byte_t b;
    b = `PNVT_UNMAPPED;
    if (cmd == `PNVT_CMD_FEATURES)
      b = `PNVT_FEATURES_VAL;                                                   // [RULE_07]
    else if (cmd == `PNVT_CMD_VOUT_FMT)
      b = {`PNVT_VOUT_NUMBER_FORMAT, `PNVT_VOUT_EXP};                          // [RULE_08] [RULE_09]
    else if (cmd == `PNVT_CMD_TURN_ON_X)
      b = hi ? {`PNVT_THR_EXP, 3'h0} : {1'b0, on_m};                           // [RULE_16]
    else if (cmd == `PNVT_CMD_TURN_ON)
      b = hi ? {`PNVT_THR_EXP, 3'h0} : {1'b0, off_m};                          // [RULE_17]
    return b;
  endfunction

  // ---- Link domain ----

  // Start and stop are data edges while the bus clock is high
  always_ff @(negedge sda_in or negedge rst_b)
  begin
    if (!rst_b)
      start_tgl <= 1'b0;
    else if (scl_clk)
      start_tgl <= ~start_tgl;
  end

  always_ff @(posedge sda_in or negedge rst_b)
  begin
    if (!rst_b)
      stop_tgl <= 1'b0;
    else if (scl_clk)
      stop_tgl <= ~stop_tgl;
  end

  // Start hold time guarantees the toggle is settled before the clock falls
  always_ff @(negedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
      start_seen <= 1'b0;
    else
      start_seen <= start_tgl;
  end
  assign new_frame = (start_seen != start_tgl);

  always_ff @(posedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_in <= '0;
      ack_in   <= 1'b1;
    end
    else if (bit_cnt == `PNVT_BIT_ACK)
      ack_in <= sda_in;
    else
      shift_in <= {shift_in[6:0], sda_in};
  end

  always_ff @(negedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nack_meta <= 1'b0;
      nack_sync <= 1'b0;
      shd_meta  <= 1'b0;
      shd_sync  <= 1'b0;
      shd_seen  <= 1'b0;
      rd_on     <= `PNVT_ON_RESET;
      rd_off    <= `PNVT_OFF_RESET;
    end
    else
    begin
      nack_meta <= nack_req;
      nack_sync <= nack_meta;
      shd_meta  <= shd_tgl;
      shd_sync  <= shd_meta;
      shd_seen  <= shd_sync;
      // The core holds the thresholds steady around each toggle
      if (shd_sync != shd_seen)
      begin
        rd_on  <= turn_on_mant;
        rd_off <= turn_off_mant;
      end
    end
  end

  assign next_rd_byte = read_byte(f_cmd, rd_idx, rd_on, rd_off);

  // Byte framing, acknowledge and read drive, all changed while the clock is low
  always_ff @(negedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt   <= '0;
      byte_idx  <= '0;
      addressed <= 1'b0;
      rd_mode   <= 1'b0;
      rd_act    <= 1'b0;
      rd_idx    <= 1'b0;
      rd_shift  <= '0;
      sda_oe    <= 1'b0;
    end
    else if (new_frame)
    begin
      bit_cnt   <= '0;
      byte_idx  <= '0;
      addressed <= 1'b0;
      rd_mode   <= 1'b0;
      rd_act    <= 1'b0;
      rd_idx    <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else if (bit_cnt == `PNVT_BIT_LAST)
    begin
      bit_cnt <= `PNVT_BIT_ACK;
      if (byte_idx == 2'h0)
      begin
        addressed <= (shift_in[7:1] == `PNVT_BUS_ADDR) && !nack_sync;
        rd_mode   <= shift_in[0];
        sda_oe    <= (shift_in[7:1] == `PNVT_BUS_ADDR) && !nack_sync;       // [RULE_03]
      end
      else
        sda_oe <= addressed && !rd_mode;
    end
    else if (bit_cnt == `PNVT_BIT_ACK)
    begin
      bit_cnt <= '0;
      if (byte_idx != 2'h3)
        byte_idx <= byte_idx + 2'h1;
      // Our own acknowledge or the host's reads as low on the acknowledge bit
      if (addressed && rd_mode && !ack_in)
      begin
        rd_act   <= 1'b1;
        rd_shift <= next_rd_byte;
        rd_idx   <= 1'b1;
        sda_oe   <= ~next_rd_byte[7];
      end
      else
      begin
        rd_act <= 1'b0;
        sda_oe <= 1'b0;
      end
    end
    else
    begin
      bit_cnt <= bit_cnt + 4'h1;
      sda_oe  <= rd_act && !rd_shift[3'h6 - bit_cnt[2:0]];
    end
  end

  // Captured frame contents stay still until the core has seen the stop
  always_ff @(negedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      f_cmd <= '0;
      f_lo  <= '0;
      f_nwr <= '0;
    end
    else if (!new_frame && bit_cnt == `PNVT_BIT_LAST)
    begin
      if (byte_idx == 2'h0 && !shift_in[0])
        f_nwr <= '0;
      else if (addressed && !rd_mode)
        case (byte_idx)
          2'h1:
          begin
            f_cmd <= shift_in;
            f_nwr <= 2'h1;
          end
          2'h2:
          begin
            f_lo  <= shift_in;
            f_nwr <= 2'h2;
          end
          default: f_nwr <= (f_nwr == 2'h2) ? 2'h3 : 2'h0;
        endcase
    end
  end

  always_ff @(negedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // ---- Core domain ----

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stp_meta <= 1'b0;
      stp_sync <= 1'b0;
      stp_seen <= 1'b0;
    end
    else
    begin
      stp_meta <= stop_tgl;
      stp_sync <= stp_meta;
      stp_seen <= stp_sync;
    end
  end

  assign frame_end = (stp_sync != stp_seen);
  assign wr_frame  = frame_end && addressed && !rd_mode;
  // Only the low seven data bits are taken; the high byte is all fixed bits
  assign sel_on    = (f_cmd == `PNVT_CMD_TURN_ON_X);                              // [RULE_10]
  assign thr_write = wr_frame && (f_nwr == 2'h3)
                     && (sel_on || f_cmd == `PNVT_CMD_TURN_ON);                   // [RULE_21]
  assign order_bad = sel_on ? (snapped < turn_off_mant) : (snapped > turn_on_mant);
  assign thr_accept = thr_write && in_range && !order_bad;
  assign range_err = thr_write && !in_range;                                      // [RULE_12]
  assign order_err = thr_write && in_range && order_bad;                          // [RULE_15]

  pnvt_snap u_snap (
    .sel_on   (sel_on),
    .raw      (f_lo[6:0]),
    .in_range (in_range),
    .snapped  (snapped)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      turn_on_mant  <= `PNVT_ON_RESET;                                            // [RULE_18]
      turn_off_mant <= `PNVT_OFF_RESET;                                           // [RULE_19]
      shd_tgl       <= 1'b0;
    end
    else if (nv.load_stb)
    begin
      turn_on_mant  <= nv.load_data[13:7];                                        // [RULE_04]
      turn_off_mant <= nv.load_data[6:0];
      shd_tgl       <= ~shd_tgl;
    end
    else if (thr_accept)
    begin
      if (sel_on)
        turn_on_mant <= snapped;                                                  // [RULE_11]
      else
        turn_off_mant <= snapped;
      shd_tgl <= ~shd_tgl;
    end
  end

  // Writes to 19h and 20h match no branch, so both bytes stay fixed
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nv.store_req   <= 1'b0;
      nv.restore_req <= 1'b0;
    end
    else
    begin
      nv.store_req   <= wr_frame && f_nwr == 2'h1 && f_cmd == `PNVT_CMD_STORE
                        && !nv.busy;                                              // [RULE_01]
      nv.restore_req <= wr_frame && f_nwr == 2'h1 && f_cmd == `PNVT_CMD_RESTORE
                        && !nv.busy;                                              // [RULE_04]
    end
  end
  assign nv.save_data = {turn_on_mant, turn_off_mant};                            // [RULE_20]

  // Status flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cml_flag    <= 1'b0;
      oth_flag    <= 1'b0;
      ivd_flag    <= 1'b0;
      smbalert_oe <= 1'b0;
    end
    else
    begin
      if (range_err || order_err || nv.store_fail)
        cml_flag <= 1'b1;                                                         // [RULE_12]
      else if (clear_faults)
        cml_flag <= 1'b0;
      if (nv.store_fail)
        oth_flag <= 1'b1;                                                         // [RULE_03]
      else if (clear_faults)
        oth_flag <= 1'b0;
      if (range_err || order_err)
        ivd_flag <= 1'b1;
      else if (clear_faults)
        ivd_flag <= 1'b0;
      if (order_err)
        smbalert_oe <= 1'b1;                                                      // [RULE_15]
      else if (clear_faults)
        smbalert_oe <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      smbalert_out <= 1'b0;
    else
      smbalert_out <= 1'b0;
  end

  // The store answers after its frame is over, so the refusal lands on the next frame
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      nack_req <= 1'b0;
    else if (nv.store_fail)
      nack_req <= 1'b1;                                                           // [RULE_03]
    else if (frame_end)
      nack_req <= 1'b0;
  end

  pnvt_nvm u_nvm (
    .clk          (clk),
    .rst_b        (rst_b),
    .ctl          (nv.seq),
    .switching    (switching),
    .fault_ignore (fault_ignore),
    .drivers_off  (drivers_off),
    .conv_restart (conv_restart),
    .nvm_wr       (nvm_wr),
    .nvm_rd       (nvm_rd),
    .nvm_wdata    (nvm_wdata),
    .nvm_rdata    (nvm_rdata),
    .nvm_done     (nvm_done),
    .nvm_fail     (nvm_fail),
    .nvm_blank    (nvm_blank)
  );
endmodule
`default_nettype wire

// File: design/pnvt_consts.svh
// Command codes, field layouts, ranges and reset values of the input-threshold block
`ifndef PNVT_CONSTS_SVH
`define PNVT_CONSTS_SVH

`define PNVT_CMD_STORE     8'h15
`define PNVT_CMD_RESTORE   8'h16
`define PNVT_CMD_FEATURES  8'h19
`define PNVT_CMD_VOUT_FMT  8'h20
`define PNVT_CMD_TURN_ON   8'h36
`define PNVT_CMD_TURN_ON_X 8'h35
`define PNVT_BUS_ADDR      7'h24
`define PNVT_FEATURES_VAL  8'hb0
`define PNVT_VOUT_NUMBER_FORMAT     3'h0
`define PNVT_VOUT_EXP      5'h17
`define PNVT_THR_EXP       5'h1e
`define PNVT_MANT_FIXED    4'h0
`define PNVT_ON_RESET      7'h11
`define PNVT_OFF_RESET     7'h10
`define PNVT_ON_MIN        7'h11
`define PNVT_ON_MAX        7'h40
`define PNVT_OFF_MIN       7'h10
`define PNVT_OFF_MAX       7'h3f
`define PNVT_BIT_LAST      4'h7
`define PNVT_BIT_ACK       4'h8
`define PNVT_UNMAPPED      8'hff

`endif

// File: design/pnvt_pkg.sv
// Shared types of the input-threshold command block
package pnvt_pkg;
  typedef logic [6:0]  pnvt_mant_t;
  typedef logic [13:0] pnvt_nvm_word_t;
  typedef logic [7:0]  pnvt_byte_t;
  typedef enum logic [1:0] {NV_BOOT, NV_IDLE, NV_STORE, NV_LOAD} pnvt_nvm_state_t;
endpackage

// File: design/pnvt_nvm_if.sv
// Request and answer signals between the command logic and the nonvolatile sequencer
`timescale 1ns/1ns
`default_nettype none
interface pnvt_nvm_if;
  import pnvt_pkg::*;
  logic           store_req;
  logic           restore_req;
  pnvt_nvm_word_t save_data;
  logic           busy;
  logic           load_stb;
  pnvt_nvm_word_t load_data;
  logic           store_fail;
  modport ctl (output store_req, output restore_req, output save_data,
               input busy, input load_stb, input load_data, input store_fail);
  modport seq (input store_req, input restore_req, input save_data,
               output busy, output load_stb, output load_data, output store_fail);
endinterface
`default_nettype wire

// File: design/pnvt_snap.sv
// Range check and snap of a written threshold to its nearest supported value
`timescale 1ns/1ns
`default_nettype none
`include "pnvt_consts.svh"
module pnvt_snap (
  input  wire logic                 sel_on,
  input  wire pnvt_pkg::pnvt_mant_t raw,
  output logic                      in_range,
  output pnvt_pkg::pnvt_mant_t      snapped
);
  import pnvt_pkg::*;

  // Quarter-volt codes; the tail repeats the top entry to fill 32 slots
  localparam pnvt_mant_t ON_TABLE [32] = '{
    7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18,
    7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h20, 7'h21,
    7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h28, 7'h2a, 7'h2c,
    7'h2e, 7'h30, 7'h32, 7'h34, 7'h38, 7'h3c, 7'h40, 7'h40};
  localparam pnvt_mant_t OFF_TABLE [32] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h20,
    7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h27, 7'h29, 7'h2b,
    7'h2d, 7'h2f, 7'h30, 7'h37, 7'h3b, 7'h3f, 7'h3f, 7'h3f};

  // Ties go to the lower entry because only a strictly smaller distance wins
  function automatic pnvt_mant_t nearest(input pnvt_mant_t v, input logic use_on);
    pnvt_mant_t best;
    pnvt_mant_t best_d;
    pnvt_mant_t e;
    pnvt_mant_t d;
    best   = use_on ? ON_TABLE[0] : OFF_TABLE[0];
    best_d = 7'h7f;
    for (int i = 0; i < 32; i++)
    begin
      e = use_on ? ON_TABLE[i] : OFF_TABLE[i];
      d = (v > e) ? v - e : e - v;
      if (d < best_d)
      begin
        best   = e;
        best_d = d;
      end
    end
    return best;
  endfunction

  assign in_range = sel_on ? (raw >= `PNVT_ON_MIN && raw <= `PNVT_ON_MAX)      // [RULE_13]
                           : (raw >= `PNVT_OFF_MIN && raw <= `PNVT_OFF_MAX);   // [RULE_14]
  assign snapped  = nearest(raw, sel_on);                                       // [RULE_11]
endmodule
`default_nettype wire

// File: design/pnvt_nvm.sv
// Store, restore and power-up load sequencer for the nonvolatile settings
`timescale 1ns/1ns
`default_nettype none
module pnvt_nvm (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  pnvt_nvm_if.seq                       ctl,
  input  wire logic                     switching,
  output logic                          fault_ignore,
  output logic                          drivers_off,
  output logic                          conv_restart,
  output logic                          nvm_wr,
  output logic                          nvm_rd,
  output pnvt_pkg::pnvt_nvm_word_t      nvm_wdata,
  input  wire pnvt_pkg::pnvt_nvm_word_t nvm_rdata,
  input  wire logic                     nvm_done,
  input  wire logic                     nvm_fail,
  input  wire logic                     nvm_blank
);
  import pnvt_pkg::*;

  pnvt_nvm_state_t state;
  logic            start_store;
  logic            start_load;

  assign ctl.busy    = (state != NV_IDLE);
  assign start_store = (state == NV_IDLE) && ctl.store_req;
  assign start_load  = (state == NV_BOOT) || ((state == NV_IDLE) && !ctl.store_req
                                              && ctl.restore_req);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= NV_BOOT;
    else
      case (state)
        NV_BOOT:  state <= NV_LOAD;
        NV_IDLE:  if (start_store) state <= NV_STORE;
                  else if (start_load) state <= NV_LOAD;
        NV_STORE: if (nvm_done) state <= NV_IDLE;
        NV_LOAD:  if (nvm_done) state <= NV_IDLE;
        default:  state <= NV_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nvm_wr         <= 1'b0;
      nvm_rd         <= 1'b0;
      nvm_wdata      <= '0;
      ctl.load_stb   <= 1'b0;
      ctl.load_data  <= '0;
      ctl.store_fail <= 1'b0;
      conv_restart   <= 1'b0;
    end
    else
    begin
      nvm_wr         <= start_store;                                            // [RULE_01]
      nvm_rd         <= start_load;                                             // [RULE_04]
      if (start_store)
        nvm_wdata <= ctl.save_data;                                             // [RULE_20]
      // A blank store leaves the working registers unchanged, so after boot they keep the reset defaults
      ctl.load_stb   <= (state == NV_LOAD) && nvm_done && !nvm_fail && !nvm_blank;
      if (nvm_done)
        ctl.load_data <= nvm_rdata;
      ctl.store_fail <= (state == NV_STORE) && nvm_done && nvm_fail;            // [RULE_03]
      conv_restart   <= (state == NV_LOAD) && nvm_done && drivers_off;          // [RULE_05]
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fault_ignore <= 1'b0;
      drivers_off  <= 1'b0;
    end
    else
    begin
      if (start_store)
        fault_ignore <= 1'b1;                                                   // [RULE_02]
      else if (state == NV_STORE && nvm_done)
        fault_ignore <= 1'b0;
      // Boot load never touches the drivers; only a host restore does
      if (state == NV_IDLE && start_load && switching)
        drivers_off <= 1'b1;                                                    // [RULE_05]
      else if (state == NV_LOAD && nvm_done)
        drivers_off <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/pnvt_chk_assertions.sv
// Checker for the threshold and nonvolatile ports of the command block
`timescale 1ns/1ns
`default_nettype none
module pnvt_chk (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire logic                     switching,
  input wire logic                     nvm_rd,
  input wire logic                     nvm_wr,
  input wire logic                     nvm_done,
  input wire logic                     nvm_fail,
  input wire logic                     nvm_blank,
  input wire pnvt_pkg::pnvt_nvm_word_t nvm_rdata,
  input wire logic                     fault_ignore,
  input wire logic                     drivers_off,
  input wire logic                     conv_restart,
  input wire logic                     cml_flag,
  input wire logic                     oth_flag,
  input wire logic                     ivd_flag,
  input wire logic                     smbalert_oe,
  input wire pnvt_pkg::pnvt_mant_t     turn_on_mant,
  input wire pnvt_pkg::pnvt_mant_t     turn_off_mant
);
  import pnvt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  on_range_a: assert property (turn_on_mant inside {[7'h11:7'h40]})
    else $error("turn-on level out of range");
  off_range_a: assert property (turn_off_mant inside {[7'h10:7'h3f]})
    else $error("turn-off level out of range");
  level_order_a: assert property (turn_on_mant >= turn_off_mant)
    else $error("turn-on level below turn-off level");
  store_guard_a: assert property (nvm_wr |=> fault_ignore)
    else $error("faults not ignored during store");
  store_fail_a: assert property (nvm_done && nvm_fail && fault_ignore
    |-> ##[1:3] cml_flag && oth_flag) else $error("failed store not flagged");
  drivers_stop_a: assert property (nvm_rd && switching |=> drivers_off)
    else $error("drivers kept on during restore");
  restore_load_a: assert property (nvm_done && !nvm_fail && !nvm_blank
    && !fault_ignore |-> ##[1:3] turn_on_mant == nvm_rdata[13:7]
    && turn_off_mant == nvm_rdata[6:0]) else $error("restore did not load");
  alert_flags_a: assert property ($rose(smbalert_oe) |-> cml_flag && ivd_flag)
    else $error("alert without status flags");
  store_c: cover property (nvm_wr);
  restart_c: cover property (conv_restart);
  alert_c: cover property ($rose(smbalert_oe));
endmodule
bind pnvt_top pnvt_chk u_chk (.clk(clk), .rst_b(rst_b), .switching(switching),
  .nvm_rd(nvm_rd), .nvm_wr(nvm_wr), .nvm_done(nvm_done), .nvm_fail(nvm_fail),
  .nvm_blank(nvm_blank), .nvm_rdata(nvm_rdata), .fault_ignore(fault_ignore),
  .drivers_off(drivers_off), .conv_restart(conv_restart), .cml_flag(cml_flag),
  .oth_flag(oth_flag), .ivd_flag(ivd_flag), .smbalert_oe(smbalert_oe),
  .turn_on_mant(turn_on_mant), .turn_off_mant(turn_off_mant));
`default_nettype wire

// File: verif/pnvt_host.sv
// SMBus host model: clock runs only inside frames, data line has a pull-up
`timescale 1ns/1ns
`default_nettype none
`include "pnvt_consts.svh"
module pnvt_host (
  output logic      scl,
  output logic      sda_h,
  input  wire logic sda
);
  logic r;
  initial {scl, sda_h} = 2'b11;
  task automatic bx(input logic b, output logic q);
    sda_h = b;
    #4 scl = 1'b1;
    #7 q = sda;
    scl = 1'b0;
    #4;
  endtask
  task automatic start();
    sda_h = 1'b1;
    #4 scl = 1'b1;
    #8 sda_h = 1'b0;
    #7 scl = 1'b0;
  endtask
  // Long gap after stop keeps frames apart in the core clock domain
  task automatic stop();
    sda_h = 1'b0;
    #4 scl = 1'b1;
    #7 sda_h = 1'b1;
    #100;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, r);
    ack = !r;
  endtask
  task automatic rxb(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
    bx(last, r);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] w, input int n, output logic ok);
    logic a;
    start();
    tx({`PNVT_BUS_ADDR, 1'b0}, ok);
    tx(c, a);
    if (n > 0) tx(w[7:0], a);
    if (n > 1) tx(w[15:8], a);
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] w);
    logic a;
    start();
    tx({`PNVT_BUS_ADDR, 1'b0}, a);
    tx(c, a);
    start();
    tx({`PNVT_BUS_ADDR, 1'b1}, a);
    rxb(1'b0, w[7:0]);
    rxb(1'b1, w[15:8]);
    stop();
  endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Testbench: host frames, memory responder and result checks
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pnvt_pkg::*;
  logic clk = 1'b0, rst_b = 1'b1, switching = 1'b0, clear_faults = 1'b0;
  logic done = 1'b0, fail = 1'b0, blank = 1'b1, ok;
  logic scl, sda_h, sda_oe, sda_out, al_oe, al_out, cml, oth, ivd, fign, doff, crst, wr, rd;
  pnvt_nvm_word_t rdata = 14'h0, wdata, wsave;
  pnvt_mant_t     on_m, off_m;
  logic [15:0]    w;
  logic [2:0]     cnt = 3'h0;
  logic [1:0]     nrst = 2'h0;
  int             errors = 0, compares = 0;
  wire logic      sda = sda_h & ~sda_oe;
  always #10 clk = ~clk;
  pnvt_host host (.scl(scl), .sda_h(sda_h), .sda(sda));
  pnvt_top DUT (.clk(clk), .rst_b(rst_b), .scl_clk(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .smbalert_out(al_out), .smbalert_oe(al_oe), .switching(switching),
    .clear_faults(clear_faults), .cml_flag(cml), .oth_flag(oth), .ivd_flag(ivd),
    .fault_ignore(fign), .drivers_off(doff), .conv_restart(crst), .turn_on_mant(on_m),
    .turn_off_mant(off_m), .nvm_wr(wr), .nvm_rd(rd), .nvm_wdata(wdata), .nvm_rdata(rdata),
    .nvm_done(done), .nvm_fail(fail), .nvm_blank(blank));
  // Memory answers five cycles after each request
  always @(posedge clk)
  begin
    done <= (cnt == 3'h1);
    if (wr | rd) cnt <= 3'h5;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    if (wr) wsave <= wdata;
    if (crst) nrst <= nrst + 2'h1;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic put(input logic [7:0] c, input logic [15:0] v, input int n);
    host.wr(c, v, n, ok);
    repeat (16) @(posedge clk);
  endtask
  task automatic get(input logic [7:0] c, input logic [15:0] e);
    host.rd(c, w);
    chk(w, e);
  endtask
  task automatic clr();
    @(posedge clk) clear_faults <= 1'b1;
    @(posedge clk) clear_faults <= 1'b0;
    repeat (2) @(posedge clk);
    chk({cml, oth, ivd, al_oe, al_out, sda_out}, 16'h0);
  endtask
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
  initial
  begin
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk);
    chk(on_m, 16'h11);
    chk(off_m, 16'h10);
    get(8'h19, 16'hb0b0);
    get(8'h20, 16'h1717);
    put(8'h20, 16'h0000, 1);
    get(8'h20, 16'h1717);
    get(8'h35, 16'hf011);
    get(8'h36, 16'hf010);
    put(8'h35, 16'h0098, 2);
    get(8'h35, 16'hf018);
    put(8'h35, 16'hf040, 2);
    chk(on_m, 16'h40);
    put(8'h36, 16'h0026, 2);
    chk(off_m, 16'h25);
    put(8'h35, 16'h003a, 2);
    chk(on_m, 16'h38);
    put(8'h35, 16'h0010, 2);
    chk({on_m, cml, ivd, al_oe}, 16'h1c6);
    clr();
    put(8'h36, 16'h0040, 2);
    chk({off_m, cml, ivd, al_oe}, 16'h12e);
    clr();
    put(8'h36, 16'h003f, 2);
    chk({off_m, cml, ivd, al_oe}, 16'h12f);
    clr();
    switching <= 1'b1;
    put(8'h15, 16'h0, 0);
    chk(wsave, {7'h38, 7'h25});
    chk({fign, cml, oth}, 16'h0);
    fail <= 1'b1;
    put(8'h15, 16'h0, 0);
    chk({cml, oth}, 16'h3);
    fail <= 1'b0;
    put(8'h19, 16'h0, 0);
    chk(ok, 16'h0);
    clr();
    rdata <= {7'h20, 7'h14};
    blank <= 1'b0;
    put(8'h16, 16'h0, 0);
    chk({on_m, off_m}, {7'h20, 7'h14});
    chk({doff, nrst}, 16'h1);
    switching <= 1'b0;
    rdata <= {7'h30, 7'h10};
    put(8'h16, 16'h0, 0);
    chk({nrst, on_m, off_m}, {2'h1, 7'h30, 7'h10});
    complete_run();
  end
endmodule
`default_nettype wire
